// file: hdl/fcr_pkg.sv
package fcr_pkg;
	// -----------------------------------------
	// Register map
	// -----------------------------------------
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  ADDR_DEC_TWO  = 5'h03;
	localparam logic [4:0]  ADDR_DEC_THR  = 5'h04;
	localparam logic [4:0]  ADDR_ENC_DATA = 5'h05;
	localparam logic [4:0]  ADDR_ENC_ONE  = 5'h06;
	localparam logic [7:0]  RST_REG       = 8'h00;

	// -----------------------------------------
	// Field positions
	// -----------------------------------------
	localparam int D2_PHASE_SYNC = 0;
	localparam int D2_TOGGLE     = 1;
	localparam int D2_SWAP_ERASE = 2;
	localparam int D2_PERIPH     = 3;
	localparam int D2_DIFF_DEC   = 4;
	localparam int D2_DESCR_EN   = 5;
	localparam int D2_DESCR_ALG  = 6;
	localparam int D3_FULL_MEM   = 0;
	localparam int D3_SOFT_RST   = 2;
	localparam int ED_BIT        = 0;
	localparam int E1_SERIAL     = 0;
	localparam int E1_SOFT_RST   = 1;
	localparam int E1_RATE_LO    = 2;
	localparam int E1_RATE_HI    = 5;

	// -----------------------------------------
	// Chainback depths
	// -----------------------------------------
	localparam logic [6:0] DEPTH_FULL  = 7'h60;
	localparam logic [6:0] DEPTH_SHORT = 7'h30;

	// -----------------------------------------
	// Types
	// -----------------------------------------
	typedef enum logic {SYNC_NORMAL, SYNC_SWAP_INV} fcr_sync_t;

	typedef struct packed {
		logic              wr_en;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} fcr_bus_t;

	typedef struct packed {
		logic [2:0] r0;
		logic [2:0] r1;
		logic [2:0] r2;
		logic [2:0] erase;
	} fcr_sym_t;

	typedef struct packed {
		logic       phase_sync_en;
		logic       sync_toggle_mode;
		logic       erasure_swap_en;
		logic       dec_peripheral;
		logic       diff_dec_en;
		logic       descr_en;
		logic       descr_exact;
		logic [6:0] chainback_depth;
	} fcr_dec_cfg_t;

	typedef struct packed {
		logic       serial_out;
		logic [3:0] rate_sel;
	} fcr_enc_cfg_t;
endpackage

// file: hdl/fcr_sync_state.sv
`timescale 1ns/1ps
module fcr_sync_state (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_clear,
	input  wire logic              i_enable,
	input  wire logic              i_toggle_mode,
	input  wire logic              i_sync_change,
	output fcr_pkg::fcr_sync_t     o_state
);
	typedef struct packed {
		logic               prev;
		fcr_pkg::fcr_sync_t state;
	} fcr_ss_t;

	fcr_ss_t s_q;
	fcr_ss_t s_d;

	// Next sync state from edge or level of the change input
	always_comb begin
		s_d      = s_q;
		s_d.prev = i_sync_change;
		if (i_clear || !i_enable) begin
			s_d.state = fcr_pkg::SYNC_NORMAL;
		end else if (i_toggle_mode) begin
			s_d.state = i_sync_change ? fcr_pkg::SYNC_SWAP_INV
				: fcr_pkg::SYNC_NORMAL;
		end else if (i_sync_change && !s_q.prev) begin
			s_d.state = (s_q.state == fcr_pkg::SYNC_NORMAL)
				? fcr_pkg::SYNC_SWAP_INV
				: fcr_pkg::SYNC_NORMAL;
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_state = s_q.state;

	// Edge mode flips the state on a rising change input
	property p_toggle_edge;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_enable && !i_toggle_mode && !i_clear
			&& i_sync_change && !s_q.prev)
		|=> (o_state != $past(o_state));
	endproperty
	a_toggle_edge: assert property (p_toggle_edge)
		else $error("sync state did not flip on edge");

	// Level mode follows the change input
	property p_level_follow;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_enable && i_toggle_mode && !i_clear)
		|=> (o_state == ($past(i_sync_change)
			? fcr_pkg::SYNC_SWAP_INV : fcr_pkg::SYNC_NORMAL));
	endproperty
	a_level_follow: assert property (p_level_follow)
		else $error("sync state not following level");
endmodule // fcr_sync_state

// file: hdl/fcr_ctrl_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Toggle mode clear: sync state flips on each rising sync change edge.
// - Toggle mode set: sync change low means normal, high swap-invert.
// - Phase sync enabled lets the decoder swap and invert symbols.
// - Erasure swap bit swaps both erasures with first two symbols, only in parallel input, rate 1/2 and external erasure mode.
// - Peripheral bit routes symbols, erasures and output via the bus.
// - Differential decoder bit enables it; encoder untouched.
// - Descrambler bit enables it; scrambler untouched.
// - Algorithm bit: one exact descrambler, zero modified variant.
// - Memory bit set gives depth 96, clear gives depth 48.
// - Zero-to-one write of soft decoder reset resets the decoder.
// - Peripheral mode takes encoder data bit from the data register.
// - Encoder output mode bit: one serial, zero parallel.
// - Zero-to-one write of soft encoder reset resets the encoder.
// - Rate bits select encoder rates 1/2, 3/4, 1/3 and 7/8.
module fcr_ctrl_regs (
	input  wire logic                  I_CORE_CLK,
	input  wire logic                  I_RST_N,
	input  wire fcr_pkg::fcr_bus_t     I_BUS,
	input  wire logic                  I_SYNC_CHANGE,
	input  wire logic                  I_PARALLEL_INPUT,
	input  wire logic                  I_RATE_HALF,
	input  wire logic                  I_EXT_ERASURE,
	input  wire fcr_pkg::fcr_sym_t     I_PIN_SYM,
	input  wire fcr_pkg::fcr_sym_t     I_BUS_SYM,
	input  wire logic                  I_DECODED_BIT,
	input  wire logic                  I_DECODER_RESET_PIN,
	input  wire logic                  I_ENCODER_SERIAL_DATA_IN,
	input  wire logic                  I_ENCODER_RESET_PIN,
	input  wire logic                  I_ENC_PERIPHERAL,
	output fcr_pkg::fcr_dec_cfg_t      O_DEC_CFG,
	output fcr_pkg::fcr_enc_cfg_t      O_ENC_CFG,
	output fcr_pkg::fcr_sync_t         O_SYNC_STATE,
	output fcr_pkg::fcr_sym_t          O_DEC_SYM,
	output logic                       O_DECODED_DATA_OUTPUT,
	output logic                       O_BUS_DECODED,
	output logic                       O_DECODER_RESET,
	output logic                       O_ENCODER_RESET,
	output logic                       O_ENC_DATA,
	output logic                       O_ENC_DATA_STROBE
);
	// -----------------------------------------
	// State
	// -----------------------------------------
	typedef struct packed {
		logic [7:0]        dec_two;
		logic [7:0]        dec_three;
		logic [7:0]        enc_data;
		logic [7:0]        enc_one;
		logic              dec_rst;
		logic              enc_rst;
		logic              enc_stb;
		logic              enc_out;
		fcr_pkg::fcr_sym_t sym;
		logic              dec_pin;
		logic              dec_bus;
	} fcr_top_t;

	fcr_top_t           r_q;
	fcr_top_t           r_d;
	fcr_pkg::fcr_sync_t sync_state;
	fcr_pkg::fcr_sym_t  src_sym;
	logic               wr_dec_two;
	logic               wr_dec_three;
	logic               wr_enc_data;
	logic               wr_enc_one;
	logic               swap_active;
	logic               erase_swap;
	logic               soft_dec_rise;
	logic               soft_enc_rise;

	// -----------------------------------------
	// Address decode
	// -----------------------------------------
	function automatic logic hit(
		input fcr_pkg::fcr_bus_t b,
		input logic [4:0]        a
	);
		hit = b.wr_en && (b.addr == a);
	endfunction

	// Write strobes per register
	always_comb begin
		wr_dec_two   = 1'b0;
		wr_dec_three = 1'b0;
		wr_enc_data  = 1'b0;
		wr_enc_one   = 1'b0;
		if (hit(I_BUS, fcr_pkg::ADDR_DEC_TWO)) begin
			wr_dec_two = 1'b1;
		end else if (hit(I_BUS, fcr_pkg::ADDR_DEC_THR)) begin
			wr_dec_three = 1'b1;
		end else if (hit(I_BUS, fcr_pkg::ADDR_ENC_DATA)) begin
			wr_enc_data = 1'b1;
		end else if (hit(I_BUS, fcr_pkg::ADDR_ENC_ONE)) begin
			wr_enc_one = 1'b1;
		end
	end

	// -----------------------------------------
	// Soft reset edges
	// -----------------------------------------
	// Rising edge is written value against stored value
	assign soft_dec_rise = wr_dec_three
		&& I_BUS.data[fcr_pkg::D3_SOFT_RST]
		&& !r_q.dec_three[fcr_pkg::D3_SOFT_RST];
	assign soft_enc_rise = wr_enc_one
		&& I_BUS.data[fcr_pkg::E1_SOFT_RST]
		&& !r_q.enc_one[fcr_pkg::E1_SOFT_RST];

	// -----------------------------------------
	// Sync state machine
	// -----------------------------------------
	fcr_sync_state u_sync (
		.i_clk         (I_CORE_CLK),
		.i_rst_n       (I_RST_N),
		.i_clear       (O_DECODER_RESET),
		.i_enable      (r_q.dec_two[fcr_pkg::D2_PHASE_SYNC]),
		.i_toggle_mode (r_q.dec_two[fcr_pkg::D2_TOGGLE]),
		.i_sync_change (I_SYNC_CHANGE),
		.o_state       (sync_state)
	);

	// -----------------------------------------
	// Symbol path conditions
	// -----------------------------------------
	// Swap-invert only with phase sync on
	assign swap_active = r_q.dec_two[fcr_pkg::D2_PHASE_SYNC]
		&& (sync_state == fcr_pkg::SYNC_SWAP_INV);
	// Erasures follow the symbols only in this mode
	assign erase_swap = swap_active
		&& r_q.dec_two[fcr_pkg::D2_SWAP_ERASE]
		&& I_PARALLEL_INPUT && I_RATE_HALF
		&& I_EXT_ERASURE;
	// Symbol source per data mode
	assign src_sym = r_q.dec_two[fcr_pkg::D2_PERIPH]
		? I_BUS_SYM : I_PIN_SYM;

	// -----------------------------------------
	// Next state
	// -----------------------------------------
	always_comb begin
		r_d         = r_q;
		r_d.dec_rst = 1'b0;
		r_d.enc_rst = 1'b0;
		r_d.enc_stb = 1'b0;
		// Register writes
		if (wr_dec_two) begin
			r_d.dec_two = I_BUS.data;
		end
		if (wr_dec_three) begin
			r_d.dec_three = I_BUS.data;
		end
		if (wr_enc_data) begin
			r_d.enc_data = I_BUS.data;
		end
		if (wr_enc_one) begin
			r_d.enc_one = I_BUS.data;
		end
		// Reset outputs: pin reset follows the pin level, soft write gives one pulse
		r_d.dec_rst = soft_dec_rise
			|| I_DECODER_RESET_PIN;
		r_d.enc_rst = soft_enc_rise
			|| I_ENCODER_RESET_PIN;
		// Encoder input bit source
		if (I_ENC_PERIPHERAL) begin
			if (wr_enc_data) begin
				r_d.enc_out = I_BUS.data[fcr_pkg::ED_BIT];
				r_d.enc_stb = 1'b1;
			end
		end else begin
			r_d.enc_out = I_ENCODER_SERIAL_DATA_IN;
		end
		// Decoder symbols with swap and invert
		r_d.sym = src_sym;
		if (swap_active) begin
			r_d.sym.r0 = ~src_sym.r1;
			r_d.sym.r1 = ~src_sym.r0;
		end
		if (erase_swap) begin
			r_d.sym.erase[0] = src_sym.erase[1];
			r_d.sym.erase[1] = src_sym.erase[0];
		end
		// Decoded bit routing
		if (r_q.dec_two[fcr_pkg::D2_PERIPH]) begin
			r_d.dec_bus = I_DECODED_BIT;
			r_d.dec_pin = 1'b0;
		end else begin
			r_d.dec_pin = I_DECODED_BIT;
			r_d.dec_bus = 1'b0;
		end
		// Decoder reset clears the decoder path
		if (r_q.dec_rst) begin
			r_d.sym     = '0;
			r_d.dec_pin = 1'b0;
			r_d.dec_bus = 1'b0;
		end
		// Encoder reset clears the encoder bit
		if (r_q.enc_rst) begin
			r_d.enc_out = 1'b0;
		end
	end

	// State register
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// -----------------------------------------
	// Outputs
	// -----------------------------------------
	// Decoder configuration fields
	always_comb begin
		O_DEC_CFG.phase_sync_en    =
			r_q.dec_two[fcr_pkg::D2_PHASE_SYNC];
		O_DEC_CFG.sync_toggle_mode =
			r_q.dec_two[fcr_pkg::D2_TOGGLE];
		O_DEC_CFG.erasure_swap_en  =
			r_q.dec_two[fcr_pkg::D2_SWAP_ERASE];
		O_DEC_CFG.dec_peripheral   =
			r_q.dec_two[fcr_pkg::D2_PERIPH];
		O_DEC_CFG.diff_dec_en      =
			r_q.dec_two[fcr_pkg::D2_DIFF_DEC];
		O_DEC_CFG.descr_en         =
			r_q.dec_two[fcr_pkg::D2_DESCR_EN];
		O_DEC_CFG.descr_exact      =
			r_q.dec_two[fcr_pkg::D2_DESCR_ALG]
			&& r_q.dec_two[fcr_pkg::D2_DESCR_EN];
		O_DEC_CFG.chainback_depth  =
			r_q.dec_three[fcr_pkg::D3_FULL_MEM]
			? fcr_pkg::DEPTH_FULL
			: fcr_pkg::DEPTH_SHORT;
	end

	// Encoder configuration fields
	always_comb begin
		O_ENC_CFG.serial_out =
			r_q.enc_one[fcr_pkg::E1_SERIAL];
		O_ENC_CFG.rate_sel   = r_q.enc_one[
			fcr_pkg::E1_RATE_HI:fcr_pkg::E1_RATE_LO];
	end

	assign O_SYNC_STATE          = sync_state;
	assign O_DEC_SYM             = r_q.sym;
	assign O_DECODED_DATA_OUTPUT = r_q.dec_pin;
	assign O_BUS_DECODED         = r_q.dec_bus;
	assign O_DECODER_RESET       = r_q.dec_rst;
	assign O_ENCODER_RESET       = r_q.enc_rst;
	assign O_ENC_DATA            = r_q.enc_out;
	assign O_ENC_DATA_STROBE     = r_q.enc_stb;

	// -----------------------------------------
	// Checks
	// -----------------------------------------
	property p_dec_soft_reset;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(wr_dec_three && I_BUS.data[2]
			&& !r_q.dec_three[2])
		|=> O_DECODER_RESET ##1 (O_DEC_SYM == '0);
	endproperty
	a_dec_soft_reset: assert property (p_dec_soft_reset)
		else $error("decoder soft reset missing");

	property p_dec_no_retrigger;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(wr_dec_three && r_q.dec_three[2]
			&& !I_DECODER_RESET_PIN)
		|=> !O_DECODER_RESET;
	endproperty
	a_dec_no_retrigger: assert property (p_dec_no_retrigger)
		else $error("decoder reset without rising write");

	property p_enc_soft_reset;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(wr_enc_one && I_BUS.data[1] && !r_q.enc_one[1])
		|=> O_ENCODER_RESET ##1 !O_ENCODER_RESET
			|| $past(I_ENCODER_RESET_PIN);
	endproperty
	a_enc_soft_reset: assert property (p_enc_soft_reset)
		else $error("encoder soft reset not one pulse");

	property p_depth;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		wr_dec_three |=> (O_DEC_CFG.chainback_depth ==
			($past(I_BUS.data[0]) ? 7'h60 : 7'h30));
	endproperty
	a_depth: assert property (p_depth)
		else $error("chainback depth wrong");

	property p_rate;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		wr_enc_one |=> (O_ENC_CFG.rate_sel ==
			$past(I_BUS.data[5:2]))
			&& (O_ENC_CFG.serial_out == $past(I_BUS.data[0]));
	endproperty
	a_rate: assert property (p_rate)
		else $error("encoder rate or mode not taken");

	property p_enc_data;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_ENC_PERIPHERAL && wr_enc_data && !O_ENCODER_RESET)
		|=> O_ENC_DATA_STROBE
			&& (O_ENC_DATA == $past(I_BUS.data[0]));
	endproperty
	a_enc_data: assert property (p_enc_data)
		else $error("encoder data bit not taken");

	property p_route;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(O_DEC_CFG.dec_peripheral && !O_DECODER_RESET)
		|=> (O_DEC_SYM.r2 == $past(I_BUS_SYM.r2))
			&& !O_DECODED_DATA_OUTPUT
			&& (O_BUS_DECODED == $past(I_DECODED_BIT));
	endproperty
	a_route: assert property (p_route)
		else $error("peripheral routing wrong");

	property p_swap_erase;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(erase_swap && !O_DECODER_RESET)
		|=> (O_DEC_SYM.erase[0] == $past(src_sym.erase[1]))
			&& (O_DEC_SYM.erase[1] == $past(src_sym.erase[0]));
	endproperty
	a_swap_erase: assert property (p_swap_erase)
		else $error("erasures not swapped");

	property p_swap_sym;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(swap_active && !O_DECODER_RESET)
		|=> (O_DEC_SYM.r0 == ~$past(src_sym.r1));
	endproperty
	a_swap_sym: assert property (p_swap_sym)
		else $error("symbols not swapped and inverted");

	property p_cfg_bits;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		wr_dec_two |=> (O_DEC_CFG.diff_dec_en == $past(I_BUS.data[4]))
			&& (O_DEC_CFG.descr_en == $past(I_BUS.data[5]));
	endproperty
	a_cfg_bits: assert property (p_cfg_bits)
		else $error("decoder enables not taken");

	property p_descr_alg;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		wr_dec_two |=> (O_DEC_CFG.descr_exact
			== $past(I_BUS.data[6] && I_BUS.data[5]));
	endproperty
	a_descr_alg: assert property (p_descr_alg)
		else $error("descrambler algorithm select wrong");
endmodule // fcr_ctrl_regs

// file: tb/fcr_host.sv
`timescale 1ns/1ps
module fcr_host (
	input  wire logic         i_clk,
	output fcr_pkg::fcr_bus_t o_bus
);
	// -----------------------------------------
	// Host processor write port
	// -----------------------------------------
	// Bus quiet at time zero
	initial begin
		o_bus = '0;
	end

	// Legal bits per register, reserved ones forced to zero
	function automatic logic [7:0] legal(input logic [4:0] a);
		case (a)
			fcr_pkg::ADDR_DEC_TWO:  return 8'h7F;
			fcr_pkg::ADDR_DEC_THR:  return 8'h05;
			fcr_pkg::ADDR_ENC_DATA: return 8'h01;
			fcr_pkg::ADDR_ENC_ONE:  return 8'h3F;
			default:                return 8'hFF;
		endcase
	endfunction

	// One write, held up to the next falling edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		o_bus.wr_en = 1'b1;
		o_bus.addr  = a;
		o_bus.data  = d & legal(a);
		@(negedge i_clk);
	endtask

	// Release: address and data show the inverse of the last value
	task automatic idle();
		o_bus.wr_en = 1'b0;
		o_bus.addr  = ~o_bus.addr;
		o_bus.data  = ~o_bus.data;
	endtask
endmodule // fcr_host

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
	// -----------------------------------------
	// Signals
	// -----------------------------------------
	typedef struct {int due; int kind; logic [15:0] val;} fcr_note_t;
	logic                  clk, rst_n, sync_chg, par_in, rate_half, ext_er;
	logic                  dec_bit, drst_pin, enc_pin, erst_pin, enc_per, b;
	logic                  dout, bus_dout, drst, erst, enc_dat, enc_stb;
	fcr_pkg::fcr_bus_t     bus;
	fcr_pkg::fcr_sym_t     pin_sym, bus_sym, dec_sym;
	fcr_pkg::fcr_dec_cfg_t dec_cfg;
	fcr_pkg::fcr_enc_cfg_t enc_cfg;
	fcr_pkg::fcr_sync_t    sync_st;
	int                    cyc, n_fail, checks_done;
	logic [7:0]            d2, d3;
	fcr_note_t             q[$];
	logic [7:0]            tab[10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
		8'h20, 8'h40, 8'h60, 8'h7F, 8'h00};
	string                 nm[9] = '{"dec_cfg", "enc_cfg", "sync", "sym",
		"dec_rst", "enc_rst", "enc_data", "dec_out", "bus_out"};

	// -----------------------------------------
	// Instances
	// -----------------------------------------
	fcr_host i_fcr_host (.i_clk(clk), .o_bus(bus));
	fcr_ctrl_regs i_fcr_ctrl_regs (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus),
		.I_SYNC_CHANGE(sync_chg), .I_PARALLEL_INPUT(par_in),
		.I_RATE_HALF(rate_half), .I_EXT_ERASURE(ext_er),
		.I_PIN_SYM(pin_sym), .I_BUS_SYM(bus_sym), .I_DECODED_BIT(dec_bit),
		.I_DECODER_RESET_PIN(drst_pin), .I_ENCODER_SERIAL_DATA_IN(enc_pin),
		.I_ENCODER_RESET_PIN(erst_pin), .I_ENC_PERIPHERAL(enc_per),
		.O_DEC_CFG(dec_cfg), .O_ENC_CFG(enc_cfg), .O_SYNC_STATE(sync_st),
		.O_DEC_SYM(dec_sym), .O_DECODED_DATA_OUTPUT(dout),
		.O_BUS_DECODED(bus_dout), .O_DECODER_RESET(drst),
		.O_ENCODER_RESET(erst), .O_ENC_DATA(enc_dat),
		.O_ENC_DATA_STROBE(enc_stb));

	// -----------------------------------------
	// Expectations and comparison
	// -----------------------------------------
	// Observed value of each kind of result
	function automatic logic [15:0] seen(input int k);
		case (k)
			0: return {2'h0, dec_cfg};
			1: return {11'h0, enc_cfg};
			2: return {15'h0, sync_st};
			3: return {4'h0, dec_sym};
			4: return {15'h0, drst};
			5: return {15'h0, erst};
			6: return {14'h0, enc_stb, enc_dat};
			7: return {15'h0, dout};
			default: return {15'h0, bus_dout};
		endcase
	endfunction

	// Decoder configuration implied by the written registers
	function automatic logic [15:0] xdec();
		return {2'h0, d2[0], d2[1], d2[2], d2[3], d2[4], d2[5], d2[6] & d2[5],
			d3[0] ? fcr_pkg::DEPTH_FULL : fcr_pkg::DEPTH_SHORT};
	endfunction

	// Symbols after optional swap-invert and erasure swap
	function automatic logic [11:0] xsym(input fcr_pkg::fcr_sym_t s,
		input logic sw, input logic es);
		fcr_pkg::fcr_sym_t o;
		o = s;
		if (sw) begin
			o.r0 = ~s.r1;
			o.r1 = ~s.r0;
		end
		if (sw && es) begin
			o.erase[1:0] = {s.erase[0], s.erase[1]};
		end
		return o;
	endfunction

	task automatic exp(input int dly, input int k, input logic [15:0] v);
		q.push_back('{cyc + dly, k, v});
	endtask

	task automatic check(input int k, input logic [15:0] e);
		logic [15:0] s;
		s = seen(k);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm[k], e, s);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic w(input logic [4:0] a, input logic [7:0] d);
		i_fcr_host.wr(a, d);
		i_fcr_host.idle();
		@(negedge clk);
	endtask

	task automatic wd2(input logic [7:0] v);
		d2 = v;
		exp(1, 0, xdec());
		w(fcr_pkg::ADDR_DEC_TWO, v);
	endtask

	// One symbol cycle through the decoder input path
	task automatic sstep(input logic sw, input logic es);
		pin_sym = 12'($urandom);
		bus_sym = 12'($urandom);
		dec_bit = 1'($urandom);
		exp(1, 3, {4'h0, xsym(d2[3] ? bus_sym : pin_sym,
			sw, es)});
		exp(1, d2[3] ? 8 : 7, {15'h0, dec_bit});
		exp(1, d2[3] ? 7 : 8, 16'h0000);
		tick(1);
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Monitor takes due notes off the queue at each falling edge
	always @(negedge clk) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			check(q[0].kind, q[0].val);
			void'(q.pop_front());
		end
	end

	// -----------------------------------------
	// Clock, cycle count and timeout
	// -----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			complete_run();
		end
	end

	// -----------------------------------------
	// Scenarios
	// -----------------------------------------
	initial begin
		{rst_n, sync_chg, par_in, rate_half, ext_er, dec_bit} = '0;
		{drst_pin, enc_pin, erst_pin, enc_per, b} = '0;
		pin_sym = '0;
		bus_sym = '0;
		{d2, d3, cyc, n_fail, checks_done} = '0;
		void'($urandom(88));
		tick(5);
		rst_n = 1'b1;
		exp(1, 0, 16'h0030);
		exp(1, 1, 16'h0000);
		tick(2);
		foreach (tab[i]) wd2(tab[i]);
		d3 = 8'h01;
		exp(1, 0, xdec());
		w(fcr_pkg::ADDR_DEC_THR, d3);
		exp(1, 0, xdec());
		w(5'h07, 8'hFF);
		exp(1, 0, xdec());
		w(5'h02, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			exp(1, 1, {11'h0, 1'(i), 4'(1 << i)});
			w(fcr_pkg::ADDR_ENC_ONE, 8'(((1 << i) << 2) | (i & 1)));
		end
		// Soft resets: pulse, none on a repeated one, rearm back to back
		exp(1, 4, 16'h0001);
		exp(2, 4, 16'h0000);
		w(fcr_pkg::ADDR_DEC_THR, 8'h05);
		exp(1, 4, 16'h0000);
		w(fcr_pkg::ADDR_DEC_THR, 8'h05);
		exp(2, 4, 16'h0001);
		i_fcr_host.wr(fcr_pkg::ADDR_DEC_THR, 8'h01);
		i_fcr_host.wr(fcr_pkg::ADDR_DEC_THR, 8'h05);
		i_fcr_host.idle();
		tick(1);
		exp(1, 5, 16'h0001);
		exp(2, 5, 16'h0000);
		w(fcr_pkg::ADDR_ENC_ONE, 8'h23);
		exp(1, 5, 16'h0000);
		w(fcr_pkg::ADDR_ENC_ONE, 8'h23);
		// Pin resets with the soft bits held at zero
		w(fcr_pkg::ADDR_DEC_THR, 8'h01);
		w(fcr_pkg::ADDR_ENC_ONE, 8'h21);
		{drst_pin, erst_pin} = 2'h3;
		exp(1, 4, 16'h0001);
		exp(1, 5, 16'h0001);
		tick(3);
		{drst_pin, erst_pin} = 2'h0;
		exp(3, 4, 16'h0000);
		exp(3, 5, 16'h0000);
		tick(3);
		// Encoder data from the register, then from the pin
		enc_per = 1'b1;
		repeat (3) begin
			b = 1'($urandom);
			exp(1, 6, {14'h0, 1'b1, b});
			exp(2, 6, {14'h0, 1'b0, b});
			w(fcr_pkg::ADDR_ENC_DATA, {7'h0, b});
		end
		enc_per = 1'b0;
		repeat (3) begin
			enc_pin = 1'($urandom);
			exp(1, 6, {14'h0, 1'b0, enc_pin});
			tick(1);
		end
		// Symbol routing: pins, then the bus
		wd2(8'h00);
		repeat (4) sstep(1'b0, 1'b0);
		wd2(8'h08);
		repeat (4) sstep(1'b0, 1'b0);
		// Sync state: edge mode, then level mode
		wd2(8'h01);
		sync_chg = 1'b1;
		exp(1, 2, 16'h0001);
		tick(2);
		sync_chg = 1'b0;
		exp(1, 2, 16'h0001);
		tick(2);
		sync_chg = 1'b1;
		exp(1, 2, 16'h0000);
		tick(2);
		wd2(8'h03);
		exp(1, 2, 16'h0001);
		tick(1);
		sync_chg = 1'b0;
		exp(1, 2, 16'h0000);
		tick(1);
		sync_chg = 1'b1;
		exp(1, 2, 16'h0001);
		tick(1);
		// Swap-invert with and without the erasure swap
		{par_in, rate_half, ext_er} = 3'h7;
		wd2(8'h07);
		repeat (3) sstep(1'b1, 1'b1);
		rate_half = 1'b0;
		repeat (3) sstep(1'b1, 1'b0);
		rate_half = 1'b1;
		wd2(8'h03);
		repeat (2) sstep(1'b1, 1'b0);
		wd2(8'h02);
		exp(1, 2, 16'h0000);
		sstep(1'b0, 1'b0);
		tick(3);
		complete_run();
	end
endmodule // tb
